// ---- fls_pkg.sv ----
// Purpose: constants and types for the frequency/level list sequencer
// Assumes: one list of fixed depth, one system clock at 200 MHz
// Notes: timing counts derived from printed times
package fls_pkg;
  localparam int IDX_W = 6;
  localparam int DEPTH = 64;
  localparam int FREQ_W = 32;
  localparam int LEVEL_W = 16;
  localparam int HW_W = 32;
  localparam int DWELL_W = 32;
  localparam int CLK_PERIOD_PS = 5000;
  // settling window inside every step that changes frequency, in ns
  localparam int SETTLE_NS = 50;
  localparam int SETTLE_CYC = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] SETTLE_CNT = 8'(SETTLE_CYC);
  localparam logic [IDX_W-1:0] IDX_RST = 6'h00;
  localparam logic [IDX_W-1:0] IDX_STOP_RST = 6'h3f;
  localparam logic BLANK_RST = 1'b1;
  localparam logic [DWELL_W-1:0] DWELL_RST = 32'h00000001;

  typedef enum logic [2:0] {
    FLS_AUTO,
    FLS_SINGLE,
    FLS_STEP,
    FLS_EXT_SINGLE,
    FLS_EXT_STEP
  } fls_mode_t;

  typedef struct packed {
    logic [FREQ_W-1:0] freq;
    logic [LEVEL_W-1:0] level;
  } fls_entry_t;

  typedef struct packed {
    logic go;
    logic col_level;
    logic [IDX_W-1:0] from;
    logic [IDX_W:0] range;
    logic [FREQ_W-1:0] start;
    logic [FREQ_W-1:0] inc;
  } fls_fill_t;

  typedef struct packed {
    logic en;
    logic [IDX_W-1:0] idx;
    fls_entry_t data;
  } fls_wr_t;
endpackage

// ---- fls_sequencer.sv ----
// Purpose: steps the source through a stored frequency/level table
// Assumes: command inputs are one-cycle pulses on sys_clk; trigger pin is asynchronous
// Notes: hardware settings are a derived word per entry, learned when list on finds them unlearned, or on a learn command
`timescale 1ns/1ps

// Notes on behaviour
// RULE1: switching list on runs at once if learned, else learns first then runs
// RULE2: list on forces sweep enable output off
// RULE3: auto mode steps start to stop, wraps, repeats forever
// RULE4: entering auto from another mode restarts at first entry
// RULE5: selecting single waits; one pass starts on execute
// RULE6: execute accepted only in single mode
// RULE7: entering step halts; output follows written current index
// RULE8: external single waits for trigger edge, then one timed pass
// RULE9: external step advances one entry per trigger edge
// RULE10: reset command returns pointer to range start in any mode
// RULE11: auto, single, external single hold each entry for dwell time
// RULE12: step modes ignore dwell; hold until index change or trigger
// RULE13: dwell is full step period; settling falls inside it
// RULE14: blanking enabled blanks output on each frequency change; else never
// RULE15: learn command re-derives and replaces stored hardware settings
// RULE16: only entries from start to stop index are processed
// RULE17: trigger slope selectable; only that polarity counts
// RULE18: fill writes chosen column over row range, start plus increment
// RULE19: trigger synchronised and edge detected to one-cycle pulse
// RULE20: finished single passes hold last entry and wait again
module fls_sequencer (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic list_on,
  input wire logic sweep_req,
  input wire fls_pkg::fls_mode_t mode,
  input wire logic exec_cmd,
  input wire logic reset_cmd,
  input wire logic learn_cmd,
  input wire logic [fls_pkg::IDX_W-1:0] cur_index,
  input wire logic [fls_pkg::IDX_W-1:0] start_idx,
  input wire logic [fls_pkg::IDX_W-1:0] stop_idx,
  input wire logic [fls_pkg::DWELL_W-1:0] dwell_cycles,
  input wire logic output_blank_on_retune,
  input wire logic trig_falling,
  input wire logic instrument_trigger_input,
  input wire fls_pkg::fls_wr_t table_wr,
  input wire fls_pkg::fls_fill_t fill_cmd,
  output fls_pkg::fls_entry_t out_entry_q,
  output logic [fls_pkg::HW_W-1:0] out_hw_q,
  output logic rf_blank_q,
  output logic sweep_on_q,
  output logic running_q,
  output logic learning_q,
  output logic learned_q,
  output logic fill_busy_q,
  output logic [fls_pkg::IDX_W-1:0] idx_q
);
  typedef enum logic [1:0] {FLS_OFF, FLS_LEARN, FLS_WAIT, FLS_RUN} fls_state_t;

  fls_pkg::fls_entry_t table_mem [fls_pkg::DEPTH];
  logic [fls_pkg::HW_W-1:0] hw_mem [fls_pkg::DEPTH];

  fls_state_t st_q, st_d;
  fls_pkg::fls_mode_t mode_q;
  logic [fls_pkg::IDX_W-1:0] idx_d;
  logic [fls_pkg::DWELL_W-1:0] cnt_q, cnt_d;
  logic [7:0] settle_q;
  logic trig_s1_q, trig_s2_q, trig_s3_q;
  logic [fls_pkg::IDX_W-1:0] fill_row_q;
  logic [fls_pkg::IDX_W:0] fill_left_q;
  logic [fls_pkg::FREQ_W-1:0] fill_val_q;
  logic fill_col_q;

  // sync first stage feeds only the second stage
  // RULE19: two-stage sync and edge
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end else begin
      trig_s1_q <= instrument_trigger_input;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end

  // RULE17: polarity select
  wire trig_rise = trig_s2_q & ~trig_s3_q;
  wire trig_fall = ~trig_s2_q & trig_s3_q;
  wire trig_pulse = trig_falling ? trig_fall : trig_rise;

  wire mode_timed = (mode == fls_pkg::FLS_AUTO) || (mode == fls_pkg::FLS_SINGLE) ||
                    (mode == fls_pkg::FLS_EXT_SINGLE);
  wire mode_chg = (mode != mode_q);
  wire at_stop = (idx_q == stop_idx);
  // RULE16: pointer stays within range
  wire out_range = (idx_q < start_idx) || (idx_q > stop_idx);
  wire [fls_pkg::IDX_W-1:0] idx_next = (at_stop || out_range) ? start_idx :
                                       fls_pkg::IDX_W'(idx_q + 1'b1);
  wire [fls_pkg::IDX_W-1:0] idx_manual = (cur_index < start_idx) ? start_idx :
                                         (cur_index > stop_idx) ? stop_idx : cur_index;
  // RULE13: dwell is the whole step period
  wire dwell_tick = (cnt_q + 32'h00000001 >= dwell_cycles);
  // RULE6: execute only in single
  wire exec_ok = exec_cmd && (mode == fls_pkg::FLS_SINGLE);
  wire entry_run = (mode == fls_pkg::FLS_AUTO);
  wire table_write = fill_busy_q || (table_wr.en && !fill_busy_q);

  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    cnt_d = 32'h00000000;
    case (st_q)
      FLS_OFF: begin
        if (list_on) begin
          idx_d = start_idx;
          // RULE1: learn only when learned_q is clear
          st_d = learned_q ? (entry_run ? FLS_RUN : FLS_WAIT) : FLS_LEARN;
        end
      end
      FLS_LEARN: begin
        idx_d = idx_next;
        if (at_stop) begin
          idx_d = start_idx;
          st_d = entry_run ? FLS_RUN : FLS_WAIT;
        end
      end
      FLS_WAIT: begin
        case (mode)
          fls_pkg::FLS_AUTO: st_d = FLS_RUN;
          // RULE5: pass starts on execute
          fls_pkg::FLS_SINGLE: if (exec_ok) begin
            st_d = FLS_RUN;
            idx_d = start_idx;
          end
          // RULE8: external single start
          fls_pkg::FLS_EXT_SINGLE: if (trig_pulse) begin
            st_d = FLS_RUN;
            idx_d = start_idx;
          end
          // RULE7: index follows written value
          fls_pkg::FLS_STEP: idx_d = idx_manual;
          // RULE9: one entry per trigger
          fls_pkg::FLS_EXT_STEP: if (trig_pulse) idx_d = idx_next;
          default: st_d = FLS_WAIT;
        endcase
      end
      FLS_RUN: begin
        // RULE12: untimed modes leave the run state
        if (!mode_timed) begin
          st_d = FLS_WAIT;
        end else if (dwell_tick) begin
          // RULE11: advance after dwell
          if (at_stop && mode != fls_pkg::FLS_AUTO) begin
            // RULE20: hold last, wait again
            st_d = FLS_WAIT;
          end else begin
            // RULE3: wrap to start
            idx_d = idx_next;
          end
        end else begin
          cnt_d = cnt_q + 32'h00000001;
        end
      end
      default: st_d = FLS_OFF;
    endcase
    if (st_q != FLS_OFF && st_q != FLS_LEARN && mode_chg) begin
      idx_d = start_idx;
      cnt_d = 32'h00000000;
      // RULE4: auto restarts at first entry
      st_d = entry_run ? FLS_RUN : FLS_WAIT;
    end
    if (st_q != FLS_OFF && learn_cmd) begin
      // RULE15: relearn on request
      st_d = FLS_LEARN;
      idx_d = start_idx;
    end else if (reset_cmd) begin
      // RULE10: back to range start
      idx_d = start_idx;
      cnt_d = 32'h00000000;
    end
    if (!list_on) begin
      st_d = FLS_OFF;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q <= FLS_OFF;
      mode_q <= fls_pkg::FLS_AUTO;
      idx_q <= fls_pkg::IDX_RST;
      cnt_q <= 32'h00000000;
    end else begin
      st_q <= st_d;
      mode_q <= mode;
      idx_q <= idx_d;
      cnt_q <= cnt_d;
    end
  end

  // RULE15: derived settings replace old ones
  always_ff @(posedge sys_clk) begin
    if (st_q == FLS_LEARN) begin
      hw_mem[idx_q] <= table_mem[idx_q].freq ^ {table_mem[idx_q].level, 16'h0000};
    end
  end

  // learned set wins over an invalidating table write
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      learned_q <= 1'b0;
    end else if (st_q == FLS_LEARN && at_stop) begin
      learned_q <= 1'b1;
    end else if (table_write) begin
      learned_q <= 1'b0;
    end
  end

  // fill has priority; plain writes during a fill are dropped
  // RULE18: start value then increments
  always_ff @(posedge sys_clk) begin
    if (fill_busy_q) begin
      if (fill_col_q) begin
        table_mem[fill_row_q].level <= fill_val_q[fls_pkg::LEVEL_W-1:0];
      end else begin
        table_mem[fill_row_q].freq <= fill_val_q;
      end
    end else if (table_wr.en) begin
      table_mem[table_wr.idx] <= table_wr.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fill_busy_q <= 1'b0;
      fill_row_q <= fls_pkg::IDX_RST;
      fill_left_q <= 7'h00;
      fill_val_q <= 32'h00000000;
      fill_col_q <= 1'b0;
    end else if (!fill_busy_q) begin
      fill_busy_q <= fill_cmd.go && (fill_cmd.range != 7'h00);
      fill_row_q <= fill_cmd.from;
      fill_left_q <= fill_cmd.range;
      fill_val_q <= fill_cmd.start;
      fill_col_q <= fill_cmd.col_level;
    end else begin
      fill_busy_q <= (fill_left_q > 7'h01) && (fill_row_q != 6'h3f);
      fill_row_q <= fls_pkg::IDX_W'(fill_row_q + 1'b1);
      fill_left_q <= 7'(fill_left_q - 1'b1);
      fill_val_q <= fill_val_q + fill_cmd.inc;
    end
  end

  wire live = (st_q == FLS_RUN) || (st_q == FLS_WAIT);
  wire retune = live && (table_mem[idx_q].freq != out_entry_q.freq);

  // settling counts inside the dwell, so net settled time is shorter
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      out_entry_q <= '0;
      out_hw_q <= 32'h00000000;
      settle_q <= 8'h00;
      rf_blank_q <= 1'b0;
      sweep_on_q <= 1'b0;
      running_q <= 1'b0;
      learning_q <= 1'b0;
    end else begin
      if (live) begin
        out_entry_q <= table_mem[idx_q];
        out_hw_q <= hw_mem[idx_q];
      end
      settle_q <= retune ? fls_pkg::SETTLE_CNT :
                  (settle_q != 8'h00) ? 8'(settle_q - 1'b1) : 8'h00;
      // RULE14: blank on retune when enabled
      rf_blank_q <= output_blank_on_retune && (retune || settle_q > 8'h01);
      // RULE2: list mode forces sweep off
      sweep_on_q <= sweep_req && !list_on;
      running_q <= (st_d == FLS_RUN);
      learning_q <= (st_d == FLS_LEARN);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_sweep_excl: assert property (list_on |=> !sweep_on_q) // RULE2
    else $error("sweep on during list mode");
  a_auto_wrap: assert property ((st_q == FLS_RUN) && mode == fls_pkg::FLS_AUTO && !mode_chg &&
      at_stop && dwell_tick && list_on && !reset_cmd && !learn_cmd |=> idx_q == start_idx) // RULE3
    else $error("auto did not wrap");
  a_auto_entry: assert property (st_q == FLS_WAIT && mode_chg && mode == fls_pkg::FLS_AUTO &&
      list_on && !learn_cmd |=> st_q == FLS_RUN && idx_q == $past(start_idx)) // RULE4
    else $error("auto entry not at start");
  a_exec_gate: assert property (st_q == FLS_WAIT && exec_cmd && mode != fls_pkg::FLS_SINGLE &&
      mode == mode_q && mode != fls_pkg::FLS_AUTO && !trig_pulse |=> st_q != FLS_RUN) // RULE6
    else $error("execute accepted outside single");
  a_step_halt: assert property (st_q == FLS_RUN && mode == fls_pkg::FLS_STEP
      |=> st_q != FLS_RUN) // RULE7
    else $error("step mode did not halt");
  a_extstep_hold: assert property (st_q == FLS_WAIT && mode == fls_pkg::FLS_EXT_STEP &&
      mode == mode_q && !trig_pulse && !reset_cmd && !learn_cmd && list_on
      |=> $stable(idx_q)) // RULE9
    else $error("ext step moved without trigger");
  a_reset_start: assert property (reset_cmd && !learn_cmd && list_on && st_q != FLS_OFF
      |=> idx_q == $past(start_idx)) // RULE10
    else $error("reset did not return to start");
  a_dwell_hold: assert property (st_q == FLS_RUN && mode_timed && !dwell_tick && !mode_chg &&
      !reset_cmd && !learn_cmd && list_on |=> $stable(idx_q)) // RULE11
    else $error("entry left before dwell");
  a_blank_off: assert property (!output_blank_on_retune |=> !rf_blank_q) // RULE14
    else $error("blank while disabled");
  a_learn_first: assert property (st_q == FLS_OFF && list_on && !learned_q
      |=> st_q == FLS_LEARN) // RULE1
    else $error("unlearned list not learned");
  a_single_hold: assert property (st_q == FLS_RUN && mode == fls_pkg::FLS_SINGLE && at_stop &&
      dwell_tick && !mode_chg && !reset_cmd && !learn_cmd && list_on
      |=> st_q == FLS_WAIT && $stable(idx_q)) // RULE20
    else $error("single pass did not hold last");
  a_ext_advance: assert property (st_q == FLS_WAIT && mode == fls_pkg::FLS_EXT_STEP &&
      mode == mode_q && trig_pulse && !reset_cmd && !learn_cmd && list_on
      |=> idx_q == $past(idx_next)) // RULE9
    else $error("ext step did not advance one entry");
  a_single_wait: assert property (st_q == FLS_WAIT && mode == fls_pkg::FLS_SINGLE &&
      mode == mode_q && !exec_cmd && !learn_cmd && list_on |=> st_q == FLS_WAIT) // RULE5
    else $error("single started without execute");
  a_xsingle_start: assert property (st_q == FLS_WAIT && mode == fls_pkg::FLS_EXT_SINGLE &&
      mode == mode_q && trig_pulse && !learn_cmd && list_on
      |=> st_q == FLS_RUN && idx_q == $past(start_idx)) // RULE8
    else $error("ext single did not start at range start");
  a_blank_on: assert property (output_blank_on_retune && retune |=> rf_blank_q) // RULE14
    else $error("no blank on frequency change");
  a_fill_step: assert property (fill_busy_q && fill_left_q > 7'h01 && fill_row_q != 6'h3f
      |=> fill_busy_q && fill_row_q == 6'($past(fill_row_q) + 6'h01)) // RULE18
    else $error("fill did not move to next row");
  a_trig_once: assert property (trig_rise |=> !trig_rise) // RULE19
    else $error("trigger pulse longer than one cycle");

  c_auto_wrap: cover property (st_q == FLS_RUN && mode == fls_pkg::FLS_AUTO && at_stop &&
      dwell_tick);
  c_ext_single: cover property (st_q == FLS_WAIT && mode == fls_pkg::FLS_EXT_SINGLE &&
      trig_pulse);
  c_learn_done: cover property (st_q == FLS_LEARN ##1 st_q != FLS_LEARN);
  c_blank: cover property (rf_blank_q);
  c_step_index: cover property (st_q == FLS_WAIT && mode == fls_pkg::FLS_STEP &&
      idx_d != idx_q);
endmodule

// ---- fls_sequencer_test.sv ----
// Purpose: self-checking bench for the list sequencer
// Assumes: table loaded by the fill engine; range 2..5, dwell 16
// Notes: fill loads the table; one direct write checks relearning
`timescale 1ns/1ps
module fls_sequencer_test;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic list_on = 1'b0;
  logic sweep_req = 1'b1;
  fls_pkg::fls_mode_t mode = fls_pkg::FLS_AUTO;
  logic exec_cmd = 1'b0;
  logic reset_cmd = 1'b0;
  logic learn_cmd = 1'b0;
  logic [5:0] cur_index = 6'h00;
  logic [5:0] start_idx = 6'h02;
  logic [5:0] stop_idx = 6'h05;
  logic [31:0] dwell_cycles = 32'h00000010;
  logic blank_en = 1'b1;
  logic trig_falling = 1'b0;
  logic fire = 1'b0;
  logic [3:0] trig_w = 4'h2;
  logic trig_pin;
  fls_pkg::fls_wr_t table_wr = '0;
  fls_pkg::fls_fill_t fill_cmd = '0;
  fls_pkg::fls_entry_t out_entry_q;
  logic [31:0] out_hw_q;
  logic [5:0] idx_q;
  logic rf_blank_q, sweep_on_q, running_q, learning_q, learned_q, fill_busy_q;
  int fail_count = 0;
  int tests_run = 0;
  localparam logic [5:0] ROW_IN[5] = '{6'h03, 6'h00, 6'h09, 6'h05, 6'h02};
  localparam logic [5:0] ROW_EXP[5] = '{6'h03, 6'h02, 6'h05, 6'h05, 6'h02};

  always #2.5 sys_clk = ~sys_clk;

  fls_sequencer i_dut (
    .sys_clk(sys_clk), .reset(reset), .list_on(list_on), .sweep_req(sweep_req),
    .mode(mode), .exec_cmd(exec_cmd), .reset_cmd(reset_cmd), .learn_cmd(learn_cmd),
    .cur_index(cur_index), .start_idx(start_idx), .stop_idx(stop_idx),
    .dwell_cycles(dwell_cycles), .output_blank_on_retune(blank_en),
    .trig_falling(trig_falling), .instrument_trigger_input(trig_pin),
    .table_wr(table_wr), .fill_cmd(fill_cmd), .out_entry_q(out_entry_q),
    .out_hw_q(out_hw_q), .rf_blank_q(rf_blank_q), .sweep_on_q(sweep_on_q),
    .running_q(running_q), .learning_q(learning_q), .learned_q(learned_q),
    .fill_busy_q(fill_busy_q), .idx_q(idx_q)
  );

  fls_trig_src i_src (.sys_clk(sys_clk), .fire(fire), .width(trig_w), .pin(trig_pin));

  function automatic logic [31:0] freq_of(input logic [5:0] i);
    return 32'h00001000 + {26'h0, i} * 32'h00000010;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // 0 running, 1 learning, 2 learned, 3 fill busy
  task automatic wait_sig(input int w, input logic v, input int lim);
    logic s;
    int k;
    s = ~v;
    k = 0;
    while (s !== v && k < lim) begin
      tick(1);
      k++;
      case (w)
        0: s = running_q;
        1: s = learning_q;
        2: s = learned_q;
        default: s = fill_busy_q;
      endcase
    end
    if (s !== v) begin
      $display("unexpected timeout on status %0d", w);
      fail_count++;
      finish_test();
    end
  endtask

  // 0 execute, 1 list reset, 2 learn, 3 trigger pulse
  task automatic pulse(input int w);
    case (w)
      0: exec_cmd <= 1'b1;
      1: reset_cmd <= 1'b1;
      2: learn_cmd <= 1'b1;
      default: fire <= 1'b1;
    endcase
    tick(1);
    {exec_cmd, reset_cmd, learn_cmd, fire} <= 4'h0;
  endtask

  task automatic fill(input logic col, input logic [31:0] st, input logic [31:0] inc);
    fill_cmd <= '{1'b1, col, 6'h00, 7'h10, st, inc};
    tick(1);
    fill_cmd.go <= 1'b0;
    wait_sig(3, 1'b1, 4);
    wait_sig(3, 1'b0, 40);
  endtask

  task automatic ext_pulse(input logic [3:0] w, input logic [5:0] e);
    trig_w <= w;
    pulse(3);
    tick(16);
    chk("ext_idx", 48'(e), 48'(idx_q));
  endtask

  // blank checks skip the first entry, whose start time is unknown
  task automatic run_auto(input int cyc, input logic ben);
    logic [5:0] prev;
    int cnt;
    int n;
    prev = idx_q;
    cnt = 0;
    n = 0;
    repeat (cyc) begin
      tick(1);
      cnt++;
      if (idx_q !== prev) begin
        chk("auto_next", 48'((prev == stop_idx) ? start_idx : prev + 6'h01), 48'(idx_q));
        if (n > 0) chk("dwell", 48'(dwell_cycles), 48'(cnt));
        prev = idx_q;
        cnt = 0;
        n++;
      end
      if (n > 0 && cnt == 3) chk("blank_on", 48'(ben), 48'(rf_blank_q));
      if (n > 0 && cnt == 3) chk("auto_freq", 48'(freq_of(prev)), 48'(out_entry_q.freq));
      if (n > 0 && cnt == 14) chk("blank_off", 48'h0, 48'(rf_blank_q));
    end
  endtask

  initial begin
    tick(20);
    chk("reset_outs", 48'h0, 48'({idx_q, running_q, learning_q, learned_q, sweep_on_q}));
    reset <= 1'b0;
    tick(3);
    chk("sweep_free", 48'h1, 48'(sweep_on_q));
    fill(1'b0, 32'h00001000, 32'h00000010);
    fill(1'b1, 32'h00000000, 32'h00000001);
    $display("test reset_fill done");
    list_on <= 1'b1;
    wait_sig(1, 1'b1, 3);
    chk("sweep_off", 48'h0, 48'(sweep_on_q));
    wait_sig(2, 1'b1, 20);
    tick(1);
    chk("auto_run", 48'h1, 48'(running_q));
    run_auto(140, 1'b1);
    $display("test auto done");
    mode <= fls_pkg::FLS_STEP;
    tick(2);
    chk("step_halt", 48'h0, 48'(running_q));
    for (int i = 0; i < 5; i++) begin
      cur_index <= ROW_IN[i];
      tick(3);
      chk("step_idx", 48'(ROW_EXP[i]), 48'(idx_q));
      chk("step_entry", {freq_of(ROW_EXP[i]), 10'h0, ROW_EXP[i]}, out_entry_q);
    end
    pulse(0);
    tick(20);
    chk("step_exec", 48'h2, 48'({running_q, idx_q}));
    $display("test step done");
    mode <= fls_pkg::FLS_SINGLE;
    tick(20);
    chk("single_wait", 48'h2, 48'({running_q, idx_q}));
    pulse(0);
    wait_sig(0, 1'b1, 3);
    wait_sig(0, 1'b0, 100);
    tick(10);
    chk("single_end", 48'h5, 48'({running_q, idx_q}));
    pulse(1);
    tick(2);
    chk("list_reset", 48'h2, 48'(idx_q));
    $display("test single done");
    mode <= fls_pkg::FLS_EXT_STEP;
    tick(20);
    chk("xstep_hold", 48'h2, 48'(idx_q));
    ext_pulse(4'h2, 6'h03);
    ext_pulse(4'h2, 6'h04);
    trig_falling <= 1'b1;
    ext_pulse(4'h4, 6'h05);
    ext_pulse(4'h4, 6'h02);
    $display("test ext_step done");
    trig_falling <= 1'b0;
    mode <= fls_pkg::FLS_EXT_SINGLE;
    tick(20);
    chk("xsingle_wait", 48'h2, 48'({running_q, idx_q}));
    pulse(3);
    wait_sig(0, 1'b1, 10);
    wait_sig(0, 1'b0, 100);
    chk("xsingle_end", 48'h5, 48'(idx_q));
    $display("test ext_single done");
    blank_en <= 1'b0;
    mode <= fls_pkg::FLS_AUTO;
    tick(2);
    chk("auto_restart", 48'h2, 48'(idx_q));
    run_auto(70, 1'b0);
    list_on <= 1'b0;
    tick(2);
    list_on <= 1'b1;
    tick(3);
    chk("rerun", 48'h1, 48'({learning_q, running_q}));
    table_wr <= '{1'b1, 6'h03, '{32'h00002000, 16'h00aa}};
    tick(1);
    table_wr.en <= 1'b0;
    chk("wr_unlearn", 48'h0, 48'(learned_q));
    pulse(2);
    wait_sig(1, 1'b1, 3);
    wait_sig(1, 1'b0, 20);
    chk("relearned", 48'h1, 48'(learned_q));
    mode <= fls_pkg::FLS_STEP;
    cur_index <= 6'h03;
    tick(4);
    chk("relearn_hw", 48'h00aa2000, 48'(out_hw_q));
    chk("written_entry", 48'h0000200000aa, out_entry_q);
    $display("test learn done");
    finish_test();
  end
endmodule

// ---- fls_trig_src.sv ----
// Purpose: external trigger source model for the trigger pin
// Assumes: pin idles low; one pulse per fire request
// Notes: edges land off the clock edge, as from an unrelated source
`timescale 1ns/1ps
module fls_trig_src (
  input wire logic sys_clk,
  input wire logic fire,
  input wire logic [3:0] width,
  output logic pin
);
  initial pin = 1'b0;
  // width in clocks lets the bench fire short or long pulses
  always @(posedge sys_clk) begin
    if (fire) begin
      #2 pin = 1'b1;
      repeat (width) @(posedge sys_clk);
      #3 pin = 1'b0;
    end
  end
endmodule
